// [pib_evsrc.sv]
// Peripheral event source model: bench requests become event pulses.
// Assumes the bench holds each request for one mclk cycle.
`timescale 1ns/10ps
module pib_evsrc
(
  // Clock
  input wire logic mclk,
  // Requests from the bench
  input wire logic [7:0] ev_req,
  input wire logic [7:0] clr_req,
  // Pulses toward the bank
  output logic [7:0] src_event = 8'h00,
  output logic [7:0] src_hw_clear = 8'h00
);
  // Launched just after the edge, like peripheral logic would
  always @(posedge mclk)
  begin
    src_event <= ev_req;
    src_hw_clear <= clr_req;
  end
endmodule

// [pib_flag_bank.sv]
// Peripheral interrupt flag register with set-wins-over-clear.
// Assumes events and hardware clears are pulses from logic on mclk.
`timescale 1ns/10ps
module pib_flag_bank
  import pib_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Peripheral side
  input wire logic [7:0] src_event,
  input wire logic [7:0] src_hw_clear,
  // Software side
  input wire logic sw_wr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_clr,
  input wire logic [7:0] sw_cdata,
  input wire logic [7:0] impl_mask,
  // Flag state
  output logic [7:0] flags_ff
);

  logic [7:0] nxt_flags;
  logic [7:0] sets;
  logic [7:0] clears;

  // Sets and clears from both sides; events ignore every enable
  always_comb
  begin
    sets = src_event;
    clears = src_hw_clear & ~PIB_FLAGS_SW_MASK;
    if (sw_wr)
    begin
      sets = sets | (sw_wdata & PIB_FLAGS_SW_MASK);
      clears = clears | (~sw_wdata & PIB_FLAGS_SW_MASK);
    end
    if (sw_clr)
    begin
      clears = clears | (sw_cdata & PIB_FLAGS_SW_MASK);
    end
    // Set applied last so a same-cycle event is never lost
    nxt_flags = ((flags_ff & ~clears) | sets) & impl_mask;
  end

  // Flag storage
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      flags_ff <= PIB_FLAGS_RST;
    else
      flags_ff <= nxt_flags;
  end

endmodule

// [pib_pkg.sv]
// Shared constants for the peripheral interrupt enable bank.
// Assumes a byte-addressed 32-bit register bus; each register is one word.
package pib_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned PIB_ADDR_W = 8;
  localparam logic [7:0] PIB_OFS_FLAGS = 8'h0C;
  localparam logic [7:0] PIB_OFS_CLEAR = 8'h10;
  localparam logic [7:0] PIB_OFS_CORE = 8'h88;
  localparam logic [7:0] PIB_OFS_ENABLE = 8'h8C;

  // ----------------------------------------------------------------
  // Source bit positions, shared by enable and flag registers
  // ----------------------------------------------------------------
  localparam int unsigned PIB_BIT_SLAVE_PORT = 7;
  localparam int unsigned PIB_BIT_CONVERTER = 6;
  localparam int unsigned PIB_BIT_SERIAL_RX = 5;
  localparam int unsigned PIB_BIT_SERIAL_TX = 4;
  localparam int unsigned PIB_BIT_SYNC_SERIAL = 3;
  localparam int unsigned PIB_BIT_CAPCOMP_ONE = 2;
  localparam int unsigned PIB_BIT_TIMER_TWO = 1;
  localparam int unsigned PIB_BIT_TIMER_ONE = 0;

  // Core control register bits
  localparam int unsigned PIB_BIT_GLOBAL = 7;
  localparam int unsigned PIB_BIT_GROUP = 6;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] PIB_ENABLE_RST = 8'h00;
  localparam logic [7:0] PIB_FLAGS_RST = 8'h00;
  localparam logic [7:0] PIB_CORE_RST = 8'h00;
  // Flags software may write; serial rx/tx flags are cleared by hardware
  localparam logic [7:0] PIB_FLAGS_SW_MASK = 8'hCF;
  localparam logic [7:0] PIB_CORE_MASK = 8'hC0;

  // ----------------------------------------------------------------
  // Bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PIB_ST_IDLE = 2'b01,
    PIB_ST_ANSWER = 2'b10
  } pib_bus_state_e;

  // Bits present on this variant; absent sources read as zero
  function automatic logic [7:0] pib_impl_mask(input logic has_port,
                                               input logic has_conv);
    logic [7:0] m;
    m = 8'hFF;
    m[PIB_BIT_SLAVE_PORT] = has_port;
    m[PIB_BIT_CONVERTER] = has_conv;
    return m;
  endfunction

endpackage

// [pib_req_gate.sv]
// Combines flags, per-source enables and core enables into one request.
// Assumes all inputs are registers on mclk.
`timescale 1ns/10ps
module pib_req_gate
  import pib_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Inputs
  input wire logic [7:0] flags,
  input wire logic [7:0] enables,
  input wire logic global_irq_enable,
  input wire logic peripheral_group_enable,
  // Request to the core
  output logic irq_ff
);

  logic nxt_irq;

  // Any enabled pending source, then group and global gates
  always_comb
  begin
    nxt_irq = (|(flags & enables))
              & peripheral_group_enable
              & global_irq_enable;
  end

  // Registered so the output has no combinational path
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_ff <= 1'b0;
    else
      irq_ff <= nxt_irq;
  end

endmodule

// [pib_top.sv]
// Peripheral interrupt enable bank: enable register, flag register,
// core enable bits and one level interrupt, behind an Avalon-MM slave.
// Assumes peripheral events are single-cycle pulses on mclk and that
// the bus master holds each request until waitrequest is seen low.
//
// Functional notes
// - The enable register is 8 bits at 0x8C, read/write, zero at reset.
// - Enable bit 6 gates the converter interrupt, one permits it.
// - Enable bit 5 gates the serial receive interrupt.
// - Enable bit 4 gates the serial transmit interrupt.
// - Unimplemented bit positions read back as zero.
// - A flag register holds one flag per source that has an enable.
// - A flag sets on its condition whatever the enables hold.
// - No peripheral request passes unless the group enable is set.
// - The global enable passes unmasked requests and blocks all if clear.
`timescale 1ns/10ps
module pib_top
  import pib_pkg::*;
#(
  parameter bit HAS_SLAVE_PORT = 1'b1,
  parameter bit HAS_CONVERTER = 1'b1
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [PIB_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Peripheral event sources
  input wire logic [7:0] src_event,
  input wire logic [7:0] src_hw_clear,
  // Interrupt to the core
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [7:0] IMPL_MASK =
    pib_impl_mask(HAS_SLAVE_PORT, HAS_CONVERTER);

  pib_bus_state_e state_ff;
  pib_bus_state_e nxt_state;
  logic [31:0] readdata_ff;
  logic [31:0] nxt_readdata;
  logic waitrequest_ff;
  logic [7:0] peripheral_irq_enable_ff;
  logic [7:0] core_irq_control_ff;
  logic [7:0] peripheral_irq_flags;
  logic irq_req;
  logic req;
  logic commit;
  logic wr_commit;
  logic lane0;
  logic flags_wr;
  logic flags_clr;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------

  // A request is accepted once idle; the answer cycle drops waitrequest
  assign req = avs_read | avs_write;
  assign commit = (state_ff == PIB_ST_ANSWER) & req;
  assign wr_commit = commit & avs_write;
  assign lane0 = avs_byteenable[0];

  // Two-state slave: one cycle to look, one cycle to answer
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      PIB_ST_IDLE:
      begin
        if (req)
          nxt_state = PIB_ST_ANSWER;
      end
      PIB_ST_ANSWER:
      begin
        nxt_state = PIB_ST_IDLE;
      end
      default:
      begin
        nxt_state = PIB_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= PIB_ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Waitrequest is low only for the answer cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      waitrequest_ff <= 1'b1;
    else
      waitrequest_ff <= ~((state_ff == PIB_ST_IDLE) & req);
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Unmapped and write-only addresses read as zero
  always_comb
  begin
    nxt_readdata = 32'h0000_0000;
    unique case (avs_address)
      PIB_OFS_ENABLE:
        nxt_readdata[7:0] = peripheral_irq_enable_ff & IMPL_MASK;
      PIB_OFS_FLAGS:
        nxt_readdata[7:0] = peripheral_irq_flags;
      PIB_OFS_CORE:
        nxt_readdata[7:0] = core_irq_control_ff & PIB_CORE_MASK;
      default:
        nxt_readdata = 32'h0000_0000;
    endcase
  end

  // Read data captured in the look cycle, held through the answer
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      readdata_ff <= 32'h0000_0000;
    else if ((state_ff == PIB_ST_IDLE) & avs_read)
      readdata_ff <= nxt_readdata;
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------

  // Per-source enables; absent sources never store a one
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      peripheral_irq_enable_ff <= PIB_ENABLE_RST;
    else if (wr_commit & lane0 & (avs_address == PIB_OFS_ENABLE))
      peripheral_irq_enable_ff <= avs_writedata[7:0] & IMPL_MASK;
  end

  // Global and group enables share the core control register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      core_irq_control_ff <= PIB_CORE_RST;
    else if (wr_commit & lane0 & (avs_address == PIB_OFS_CORE))
      core_irq_control_ff <= avs_writedata[7:0] & PIB_CORE_MASK;
  end

  // Flag register: direct write and write-one-to-clear
  assign flags_wr = wr_commit & lane0 & (avs_address == PIB_OFS_FLAGS);
  assign flags_clr = wr_commit & lane0 & (avs_address == PIB_OFS_CLEAR);

  // ----------------------------------------------------------------
  // Flags and request
  // ----------------------------------------------------------------

  // Flags rise on source events regardless of any enable
  pib_flag_bank u_flags
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .src_event(src_event),
    .src_hw_clear(src_hw_clear),
    .sw_wr(flags_wr),
    .sw_wdata(avs_writedata[7:0]),
    .sw_clr(flags_clr),
    .sw_cdata(avs_writedata[7:0]),
    .impl_mask(IMPL_MASK),
    .flags_ff(peripheral_irq_flags)
  );

  // Stale flags fire at once when enabled; software clears them first
  pib_req_gate u_gate
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .flags(peripheral_irq_flags),
    .enables(peripheral_irq_enable_ff),
    .global_irq_enable(core_irq_control_ff[PIB_BIT_GLOBAL]),
    .peripheral_group_enable(core_irq_control_ff[PIB_BIT_GROUP]),
    .irq_ff(irq_req)
  );

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign avs_readdata = readdata_ff;
  assign avs_waitrequest = waitrequest_ff;
  assign irq = irq_req;

endmodule

// [pib_top_sva.sv]
// Port assertions for the peripheral interrupt enable bank.
// Assumes a bind onto pib_top; sees its ports only.
`timescale 1ns/10ps
module pib_top_sva
  import pib_pkg::*;
#(
  parameter bit HAS_SLAVE_PORT = 1'b1,
  parameter bit HAS_CONVERTER = 1'b1
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bus
  input wire logic [PIB_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Events and request
  input wire logic [7:0] src_event,
  input wire logic [7:0] src_hw_clear,
  input wire logic irq
);
  logic [7:0] en_ff;
  logic [7:0] core_ff;
  wire land = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire rdok = avs_read && !avs_waitrequest;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Shadow of landed writes; the request is judged against it
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_ff <= 8'h00;
      core_ff <= 8'h00;
    end
    else if (land && avs_address == PIB_OFS_ENABLE)
      en_ff <= avs_writedata[7:0] & {HAS_SLAVE_PORT, HAS_CONVERTER, 6'h3F};
    else if (land && avs_address == PIB_OFS_CORE)
      core_ff <= avs_writedata[7:0] & PIB_CORE_MASK;
  end

  // Bus handshake and readback
  a_wait_pulse:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_answer:
    assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
    else $error("request not answered");
  a_read_upper:
    assert property (rdok |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_enable_read:
    assert property (rdok && avs_address == PIB_OFS_ENABLE
      |-> avs_readdata[7:0] == en_ff)
    else $error("enable readback wrong");

  // Interrupt request against its causes
  a_event_irq:
    assert property ((src_event & en_ff) != 8'h00 && core_ff == 8'hC0
      && !land |-> ##2 irq)
    else $error("enabled event gave no request");
  a_global_gate:
    assert property (!core_ff[PIB_BIT_GLOBAL] |=> !irq)
    else $error("request with global enable off");
  a_group_gate:
    assert property (!core_ff[PIB_BIT_GROUP] |=> !irq)
    else $error("request with group enable off");
  a_irq_cause:
    assert property ($rose(irq) |-> $past(src_event, 2) != 8'h00
      || $past(land, 2))
    else $error("request rose without cause");
  a_irq_drop:
    assert property ($fell(irq) |-> $past(land, 2)
      || $past(src_hw_clear, 2) != 8'h00)
    else $error("request fell without cause");

  // Main scenarios reached
  c_irq_rise: cover property ($rose(irq));
  c_blocked: cover property (src_event != 8'h00 && !core_ff[PIB_BIT_GROUP]);
  c_flag_read: cover property (rdok && avs_address == PIB_OFS_FLAGS);
endmodule

// [test_peripheral_irq_enable_bank.sv]
// Self-checking bench for the peripheral interrupt enable bank.
// Assumes pib_pkg, pib_top, pib_evsrc and pib_top_sva compiled first.
`timescale 1ns/10ps
module test_peripheral_irq_enable_bank
  import pib_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] ev_req = 8'h00;
  logic [7:0] clr_req = 8'h00;
  logic [7:0] src_event;
  logic [7:0] src_hw_clear;
  logic irq;
  logic [31:0] r;
  logic [7:0] ads [5] = '{8'h8C, 8'h88, 8'h0C, 8'h10, 8'h44};
  logic [7:0] cores [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};
  int err_count = 0;
  int comparisons = 0;
  int m_en = 0;
  int m_core = 0;
  int m_flg = 0;
  logic [7:0] wa;
  logic [7:0] wd;
  // Variant under test; software keeps absent sources' enables clear
  localparam bit HAS_PORT = 1'b0;
  localparam bit HAS_CONV = 1'b1;

  // Variant without a slave port, so bit 7 must stay dead
  pib_top #(.HAS_SLAVE_PORT(HAS_PORT), .HAS_CONVERTER(HAS_CONV)) i_dut
  (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .src_event(src_event), .src_hw_clear(src_hw_clear), .irq(irq)
  );
  pib_evsrc i_src
  (
    .mclk(mclk), .ev_req(ev_req), .clr_req(clr_req),
    .src_event(src_event), .src_hw_clear(src_hw_clear)
  );

  // 40 MHz clock
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
      $display("Error at %0t: reg got %h exp %h", $time, got, exp);
    if (got !== exp)
      err_count++;
  endtask

  task automatic chk_irq(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
      $display("Error at %0t: irq got %h exp %h", $time, got, exp);
    if (got !== exp)
      err_count++;
  endtask

  // Reference model of software writes; bits 5,4 only clear in hardware
  function automatic void model_wr(input int a, input int d);
    if (a == 'h8C) m_en = d & 'h7F;
    if (a == 'h88) m_core = d & 'hC0;
    if (a == 'h0C) m_flg = (m_flg & 'h30) | (d & 'h4F);
    if (a == 'h10) m_flg = m_flg & ~(d & 'h4F);
  endfunction

  function automatic int model_rd(input int a);
    return a == 'h8C ? m_en : a == 'h88 ? m_core : a == 'h0C ? m_flg : 0;
  endfunction

  // One Avalon transfer; holds everything until waitrequest is seen low
  // No local limit: only the watchdog ends a hung handshake
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge mclk);
    end
    while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
    if (wr && be[0])
      model_wr(a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a);
    bus(1'b0, a, 8'h00, 4'hF);
    chk_reg(r, 32'(model_rd(a)));
  endtask

  // Event and hardware clear pulses; set wins over a clear
  task automatic pulse(input logic [7:0] e, input logic [7:0] c);
    ev_req <= e;
    clr_req <= c;
    @(posedge mclk);
    ev_req <= 8'h00;
    clr_req <= 8'h00;
    repeat (3) @(posedge mclk);
    m_flg = (m_flg & ~(c & 'h30)) | (e & 'h7F);
    chk_irq(irq, (m_flg & m_en) != 0 && m_core == 'hC0);
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog cuts a hung handshake short
  initial
  begin
    repeat (5000) @(posedge mclk);
    err_count++;
    summarize();
  end

  // Main sequence
  initial
  begin
    r = $urandom(32'h61B58B05);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    foreach (ads[i]) rd_chk(ads[i]);
    $display("Test reset finished");
    for (int b = 0; b < 7; b++)
    begin
      bus(1'b1, 8'h10, 8'hFF, 4'hF);
      pulse(8'h00, 8'h30);
      bus(1'b1, 8'h88, 8'hC0, 4'hF);
      bus(1'b1, 8'h8C, 8'h01 << b, 4'hF);
      pulse(8'h7F & ~(8'h01 << b), 8'h00);
      pulse(8'h01 << b, 8'h00);
      rd_chk(8'h0C);
    end
    $display("Test walk finished");
    foreach (cores[i])
    begin
      bus(1'b1, 8'h88, cores[i], 4'hF);
      pulse(8'hFF, 8'h00);
      rd_chk(8'h88);
    end
    bus(1'b1, 8'h8C, 8'h00, 4'hE);
    rd_chk(8'h8C);
    $display("Test gating finished");
    for (int i = 0; i < 40; i++)
    begin
      wa = ads[$urandom % 5];
      wd = 8'($urandom);
      // Reserved enable bits of absent sources stay clear in software
      if (wa == 8'h8C)
        wd = wd & {HAS_PORT, HAS_CONV, 6'h3F};
      bus(1'b1, wa, wd, 4'($urandom));
      pulse(8'($urandom), 8'($urandom));
      rd_chk(ads[$urandom % 5]);
    end
    $display("Test random finished");
    summarize();
  end
endmodule

bind pib_top pib_top_sva #(.HAS_SLAVE_PORT(HAS_SLAVE_PORT),
  .HAS_CONVERTER(HAS_CONVERTER)) u_sva
(
  .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .src_event(src_event), .src_hw_clear(src_hw_clear), .irq(irq)
);
